// ---- src/fault_retry_sequencer.sv ----
// Purpose: automatic fault retry sequencer of a motor drive
// Assumes: fault inputs are asynchronous levels from the detectors; bus on sys_clk
// Notes:   retry wait register is in 0.1 s steps, values clamped to 0.1 to 360 s
// Function
// - After a trip and the wait, the fault is cleared and output restarts at start frequency.
// - A retry limit of zero disables retries.
// - Limits 1 to 10 give the retry count and keep the fault output low during retry.
// - Limits 101 to 110 give the count minus 100 and keep the fault output high during retry.
// - Failures beyond the allowed count raise the retry-excess fault and trip until an external reset.
// - The wait is programmable from 0.1 s to 360 s and is 1 s after power-up.
// - Fault-free running for over four waits after a retry start adds one success.
// - A successful retry clears the consecutive failure count.
// - The success counter reads the total successes and a write of zero clears it.
// - Only faults enabled by the fault select setting are retried.
// - Select 0 all, 1 overcurrent, 2 overvoltage, 3 both, 4 all but overloads, 5 OC accel/decel.
// - Only the first fault of a retry sequence is recorded for the retry reset.
// - A retry reset keeps thermal and brake duty data, unlike power-on reset.
// - No retry when the parameter storage fault is seen at power-on.
// - A non-retryable fault during the wait abandons the retry and keeps its indication.
// - With automatic restart selected, a retry restarts with the power-failure timing.
//
// Design decisions made here: the register addresses and the plain strobed port.
`timescale 1ns/1ns
`include "frs_map.svh"
module fault_retry_sequencer
	import frs_pkg::*;
#(
	parameter int NUM_FAULTS   = 15,
	parameter int TENTH_CYCLES = `FRS_TENTH_SEC_CYCLES
) (
	input  wire logic                  sys_clk,
	input  wire logic                  reset,
	input  wire frs_bus_req_t          busReq,
	output logic [15:0]                busRdata,
	input  wire logic [NUM_FAULTS-1:0] faultIn,
	input  wire logic                  powerOnDone,
	input  wire logic [15:0]           restartCoastTime,
	input  wire logic                  externalReset,
	output logic                       driveTripped,
	output logic                       faultOutput,
	output logic                       faultClearPulse,
	output logic                       restartFromStart,
	output logic                       usePowerFailTiming,
	output logic                       keepThermalData,
	output logic [NUM_FAULTS-1:0]      retryFaultRecord,
	output logic                       retryExcessFault,
	output logic                       irq
);
	logic [NUM_FAULTS-1:0] faultMeta;
	logic [NUM_FAULTS-1:0] faultSync;
	logic [NUM_FAULTS-1:0] faultPrev;
	logic                  extMeta;
	logic                  extSync;
	logic [15:0]           retryFaultSelect;
	logic [15:0]           retryLimit;
	logic [15:0]           retryWaitTime;
	logic [15:0]           retrySuccessCount;
	logic [3:0]            irqStatus;
	logic [3:0]            irqMask;
	logic                  psfAtPowerOn;
	logic                  powerOnSeen;
	frs_state_t            state;
	logic [3:0]            failCount;
	logic [31:0]           tickCount;
	logic [15:0]           tenthCount;
	logic [17:0]           watchTenths;
	logic [NUM_FAULTS-1:0] enabledMask;
	logic [NUM_FAULTS-1:0] newFault;
	logic                  anyFault;
	logic                  anyNewFault;
	logic                  newRetryable;
	logic                  newBlocked;
	logic [3:0]            allowedCount;
	logic                  retryActive;
	logic                  failFlag;
	logic [15:0]           waitClamped;
	logic                  tenthTick;
	logic                  evRetry;
	logic                  evSuccess;
	logic                  evExcess;
	logic                  evAbandon;
	logic [3:0]            irqEvents;
	logic [15:0]           next_rdata;
	localparam logic [NUM_FAULTS-1:0] OC_MASK   = NUM_FAULTS'(15'h0007);
	localparam logic [NUM_FAULTS-1:0] OV_MASK   = NUM_FAULTS'(15'h0038);
	localparam logic [NUM_FAULTS-1:0] OL_MASK   = NUM_FAULTS'(15'h00C0);
	localparam logic [NUM_FAULTS-1:0] ALL_MASK  = NUM_FAULTS'(15'h7FFF);
	localparam logic [NUM_FAULTS-1:0] OCAD_MASK = NUM_FAULTS'(15'h0005);

	// Two-flop synchronisers on the detector and reset pins
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			faultMeta <= '0;
			faultSync <= '0;
			faultPrev <= '0;
			extMeta   <= 1'b0;
			extSync   <= 1'b0;
		end else begin
			faultMeta <= faultIn;
			faultSync <= faultMeta;
			faultPrev <= faultSync;
			extMeta   <= externalReset;
			extSync   <= extMeta;
		end
	end

	always_comb begin
		case (retryFaultSelect)
			16'h0000: enabledMask = ALL_MASK;
			16'h0001: enabledMask = OC_MASK;
			16'h0002: enabledMask = OV_MASK;
			16'h0003: enabledMask = OC_MASK | OV_MASK;
			16'h0004: enabledMask = ALL_MASK & ~OL_MASK;
			16'h0005: enabledMask = OCAD_MASK;
			default:  enabledMask = '0;
		endcase
	end

	assign newFault    = faultSync & ~faultPrev;
	assign anyFault    = |faultSync;
	assign anyNewFault = |newFault;
	assign newRetryable = anyNewFault && ((newFault & ~enabledMask) == '0);
	// storage fault seen at power-on blocks retries of a new storage fault
	assign newBlocked = psfAtPowerOn && newFault[FRS_F_PSF];

	// allowed count from the limit setting
	always_comb begin
		allowedCount = 4'h0;
		if (retryLimit >= 16'h0001 && retryLimit <= 16'h000A) begin
			allowedCount = retryLimit[3:0];
		end else if (retryLimit >= 16'h0065 && retryLimit <= 16'h006E) begin
			allowedCount = 4'((retryLimit - `FRS_LIMIT_OFFSET));
		end
	end
	// zero or invalid limit disables retries
	assign retryActive = (allowedCount != 4'h0);
	assign failFlag    = (retryLimit >= 16'h0065);

	// clamp to 0.1 s .. 360 s
	assign waitClamped = (retryWaitTime < `FRS_WAIT_MIN) ? `FRS_WAIT_MIN :
		(retryWaitTime > `FRS_WAIT_MAX) ? `FRS_WAIT_MAX : retryWaitTime;

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			tickCount <= '0;
		end else if (tickCount == 32'(TENTH_CYCLES - 1)) begin
			tickCount <= '0;
		end else begin
			tickCount <= tickCount + 32'h00000001;
		end
	end
	assign tenthTick = (tickCount == 32'(TENTH_CYCLES - 1));

	// Power-on check of the storage fault, taken once after release
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			powerOnSeen  <= 1'b0;
			psfAtPowerOn <= 1'b0;
		end else if (!powerOnSeen && powerOnDone) begin
			powerOnSeen  <= 1'b1;
			psfAtPowerOn <= faultSync[FRS_F_PSF];
		end
	end

	// Sequencer
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			state            <= FRS_RUN;
			failCount        <= 4'h0;
			tenthCount       <= 16'h0000;
			watchTenths      <= 18'h00000;
			driveTripped     <= 1'b0;
			faultClearPulse  <= 1'b0;
			restartFromStart <= 1'b0;
			retryFaultRecord <= '0;
			retryExcessFault <= 1'b0;
			evRetry          <= 1'b0;
			evSuccess        <= 1'b0;
			evExcess         <= 1'b0;
			evAbandon        <= 1'b0;
		end else begin
			faultClearPulse  <= 1'b0;
			restartFromStart <= 1'b0;
			evRetry          <= 1'b0;
			evSuccess        <= 1'b0;
			evExcess         <= 1'b0;
			evAbandon        <= 1'b0;
			case (state)
				FRS_RUN, FRS_WATCH: begin
					if (state == FRS_WATCH && tenthTick) begin
						watchTenths <= watchTenths + 18'h00001;
					end
					if (anyNewFault) begin
						driveTripped <= 1'b1;
						tenthCount   <= 16'h0000;
						// keep only the first fault of the sequence
						if (failCount == 4'h0 && state == FRS_RUN) begin
							retryFaultRecord <= newFault;
						end
						if (!retryActive || !newRetryable || newBlocked) begin
							state <= FRS_LOCKED;
						end else if (failCount >= allowedCount) begin
							state            <= FRS_EXCESS;
							retryExcessFault <= 1'b1;
							evExcess         <= 1'b1;
						end else begin
							state <= FRS_WAIT;
						end
					// success after more than four waits
					end else if (state == FRS_WATCH &&
						watchTenths > {waitClamped, 2'b00}) begin
						state     <= FRS_RUN;
						evSuccess <= 1'b1;
						failCount <= 4'h0;
					end
				end
				FRS_WAIT: begin
					if (tenthTick) begin
						tenthCount <= tenthCount + 16'h0001;
					end
					if (anyNewFault && !newRetryable) begin
						state     <= FRS_LOCKED;
						evAbandon <= 1'b1;
					// clear fault and restart from start frequency
					end else if (tenthCount >= waitClamped) begin
						state            <= FRS_WATCH;
						driveTripped     <= 1'b0;
						faultClearPulse  <= 1'b1;
						restartFromStart <= 1'b1;
						failCount        <= failCount + 4'h1;
						watchTenths      <= 18'h00000;
						evRetry          <= 1'b1;
					end
				end
				default: begin
					// only an external reset leaves a locked trip
					if (extSync && !anyFault) begin
						state            <= FRS_RUN;
						driveTripped     <= 1'b0;
						retryExcessFault <= 1'b0;
						failCount        <= 4'h0;
						retryFaultRecord <= '0;
					end
				end
			endcase
		end
	end

	assign faultOutput = (state == FRS_LOCKED || state == FRS_EXCESS) ||
		(state == FRS_WAIT && failFlag);
	// power-failure restart timing when coast time set
	assign usePowerFailTiming = restartFromStart && (restartCoastTime != `FRS_COAST_NONE);
	// retry reset preserves thermal and brake data
	assign keepThermalData = faultClearPulse;

	// Interrupts: set wins over a write-one clear
	assign irqEvents = {evAbandon, evExcess, evSuccess, evRetry};
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			irqStatus <= 4'h0;
		end else if (busReq.wr && busReq.addr == `FRS_OFF_IRQ_STATUS) begin
			irqStatus <= (irqStatus & ~busReq.wdata[3:0]) | irqEvents;
		end else begin
			irqStatus <= irqStatus | irqEvents;
		end
	end
	assign irq = |(irqStatus & irqMask);

	// Register writes
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			retryFaultSelect <= 16'h0000;
			retryLimit       <= 16'h0000;
			retryWaitTime    <= `FRS_WAIT_RESET;
			irqMask          <= 4'h0;
		end else if (busReq.wr) begin
			if (busReq.addr == `FRS_OFF_FAULT_SELECT) begin
				retryFaultSelect <= busReq.wdata;
			end else if (busReq.addr == `FRS_OFF_LIMIT) begin
				retryLimit <= busReq.wdata;
			end else if (busReq.addr == `FRS_OFF_WAIT_TIME) begin
				retryWaitTime <= busReq.wdata;
			end else if (busReq.addr == `FRS_OFF_IRQ_MASK) begin
				irqMask <= busReq.wdata[3:0];
			end
		end
	end

	// success counter, a clear with an increment in the same cycle gives one
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			retrySuccessCount <= 16'h0000;
		end else if (evSuccess) begin
			retrySuccessCount <= (busReq.wr && busReq.addr == `FRS_OFF_SUCCESS_COUNT &&
				busReq.wdata == 16'h0000) ? 16'h0001 : retrySuccessCount + 16'h0001;
		end else if (busReq.wr && busReq.addr == `FRS_OFF_SUCCESS_COUNT &&
			busReq.wdata == 16'h0000) begin
			retrySuccessCount <= 16'h0000;
		end
	end

	always_comb begin
		next_rdata = 16'h0000;
		if (busReq.addr == `FRS_OFF_FAULT_SELECT) begin
			next_rdata = retryFaultSelect;
		end else if (busReq.addr == `FRS_OFF_LIMIT) begin
			next_rdata = retryLimit;
		end else if (busReq.addr == `FRS_OFF_WAIT_TIME) begin
			next_rdata = retryWaitTime;
		end else if (busReq.addr == `FRS_OFF_SUCCESS_COUNT) begin
			next_rdata = retrySuccessCount;
		end else if (busReq.addr == `FRS_OFF_STATUS) begin
			next_rdata = {8'h00, failCount, retryExcessFault, state};
		end else if (busReq.addr == `FRS_OFF_IRQ_STATUS) begin
			next_rdata = {12'h000, irqStatus};
		end else if (busReq.addr == `FRS_OFF_IRQ_MASK) begin
			next_rdata = {12'h000, irqMask};
		end
	end
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			busRdata <= 16'h0000;
		end else begin
			busRdata <= busReq.rd ? next_rdata : 16'h0000;
		end
	end

	AST_EXCESS_LOCK: assert property (@(posedge sys_clk) disable iff (reset)
		(state == FRS_EXCESS) && !extSync |=> (state == FRS_EXCESS))
		else $error("Excess trip left without reset");
	AST_NO_RETRY_ZERO: assert property (@(posedge sys_clk) disable iff (reset)
		(retryLimit == 16'h0000) |-> !evRetry)
		else $error("Retry while disabled");
	AST_CLEAR_RESTART: assert property (@(posedge sys_clk) disable iff (reset)
		(state == FRS_WAIT) && !anyNewFault && (tenthCount >= waitClamped)
		|=> faultClearPulse && restartFromStart && (state == FRS_WATCH))
		else $error("Retry did not restart");
	AST_FAULT_LOW: assert property (@(posedge sys_clk) disable iff (reset)
		(state == FRS_WAIT) && (retryLimit <= 16'h000A) |-> !faultOutput)
		else $error("Fault output during silent retry");
	AST_FAULT_HIGH: assert property (@(posedge sys_clk) disable iff (reset)
		(state == FRS_WAIT) && (retryLimit >= 16'h0065) |-> faultOutput)
		else $error("No fault output during retry");
	AST_EXCESS_RAISE: assert property (@(posedge sys_clk) disable iff (reset)
		(state == FRS_RUN || state == FRS_WATCH) && anyNewFault && retryActive &&
		newRetryable && !newBlocked && (failCount >= allowedCount)
		|=> retryExcessFault && (state == FRS_EXCESS))
		else $error("Excess fault missing");
	AST_SUCCESS_CLEAR: assert property (@(posedge sys_clk) disable iff (reset)
		evSuccess |-> (failCount == 4'h0) && (state == FRS_RUN))
		else $error("Failures not cleared on success");
	AST_ABANDON: assert property (@(posedge sys_clk) disable iff (reset)
		(state == FRS_WAIT) && anyNewFault && !newRetryable |=> (state == FRS_LOCKED))
		else $error("Retry not abandoned");
	AST_COUNT_UP: assert property (@(posedge sys_clk) disable iff (reset)
		evSuccess && !busReq.wr && (retrySuccessCount != 16'hFFFF)
		|=> retrySuccessCount == $past(retrySuccessCount) + 16'h0001)
		else $error("Success count not advanced");
endmodule // fault_retry_sequencer

// ---- src/frs_map.svh ----
// Purpose: register offsets, reset values and timing counts for the fault retry sequencer
// Assumes: 50 MHz system clock
// Notes:   wait time register is in units of 0.1 s
`ifndef FRS_MAP_SVH
`define FRS_MAP_SVH
`define FRS_OFF_FAULT_SELECT  4'h0
`define FRS_OFF_LIMIT         4'h1
`define FRS_OFF_WAIT_TIME     4'h2
`define FRS_OFF_SUCCESS_COUNT 4'h3
`define FRS_OFF_STATUS        4'h4
`define FRS_OFF_IRQ_STATUS    4'h5
`define FRS_OFF_IRQ_MASK      4'h6
`define FRS_OFF_CONTROL       4'h7
`define FRS_WAIT_RESET        16'h000A
`define FRS_WAIT_MIN          16'h0001
`define FRS_WAIT_MAX          16'h0E10
`define FRS_TENTH_SEC_NS      100000000
`define FRS_CLK_PERIOD_NS     20
`define FRS_TENTH_SEC_CYCLES  (`FRS_TENTH_SEC_NS / `FRS_CLK_PERIOD_NS)
`define FRS_LIMIT_OFFSET      16'h0064
`define FRS_COAST_NONE        16'h270F
`define FRS_IRQ_RETRY         0
`define FRS_IRQ_SUCCESS       1
`define FRS_IRQ_EXCESS        2
`define FRS_IRQ_ABANDON       3
`endif

// ---- src/frs_pkg.sv ----
// Purpose: types of the fault retry sequencer
// Assumes: nothing
// Notes:   fault vector bit order is fixed by frs_fault_idx_t
package frs_pkg;
	typedef enum logic [3:0] {
		FRS_F_OC1 = 4'h0, FRS_F_OC2 = 4'h1, FRS_F_OC3 = 4'h2,
		FRS_F_OV1 = 4'h3, FRS_F_OV2 = 4'h4, FRS_F_OV3 = 4'h5,
		FRS_F_THM = 4'h6, FRS_F_THT = 4'h7, FRS_F_BE  = 4'h8,
		FRS_F_GF  = 4'h9, FRS_F_OLT = 4'hA, FRS_F_OPT = 4'hB,
		FRS_F_OP1 = 4'hC, FRS_F_PSF = 4'hD, FRS_F_ILF = 4'hE
	} frs_fault_idx_t;
	typedef enum logic [2:0] {
		FRS_RUN    = 3'b000,
		FRS_WAIT   = 3'b001,
		FRS_WATCH  = 3'b010,
		FRS_LOCKED = 3'b011,
		FRS_EXCESS = 3'b100
	} frs_state_t;
	typedef struct packed {
		logic [3:0]  addr;
		logic [15:0] wdata;
		logic        wr;
		logic        rd;
	} frs_bus_req_t;
endpackage

// ---- test/fault_retry_sequencer_test.sv ----
// Purpose: self-checking bench of the fault retry sequencer
// Assumes: tenth-second tick shortened to 10 cycles
// Notes:   wait time set to one tenth so a retry lands within about 15 cycles
`timescale 1ns/1ns
module fault_retry_sequencer_test;
	import frs_pkg::*;
	logic         sys_clk, reset, powerOnDone, externalReset, drop;
	frs_bus_req_t busReq;
	logic [15:0]  busRdata, restartCoastTime;
	logic [14:0]  faultIn, inject, retryFaultRecord;
	logic         driveTripped, faultOutput, faultClearPulse, restartFromStart;
	logic         usePowerFailTiming, keepThermalData, retryExcessFault, irq;
	int           errCount, checks, pulses, p0;
	fault_retry_sequencer #(.NUM_FAULTS(15), .TENTH_CYCLES(10)) dut_u (.sys_clk(sys_clk),
		.reset(reset), .busReq(busReq), .busRdata(busRdata), .faultIn(faultIn),
		.powerOnDone(powerOnDone), .restartCoastTime(restartCoastTime),
		.externalReset(externalReset), .driveTripped(driveTripped), .faultOutput(faultOutput),
		.faultClearPulse(faultClearPulse), .restartFromStart(restartFromStart),
		.usePowerFailTiming(usePowerFailTiming), .keepThermalData(keepThermalData),
		.retryFaultRecord(retryFaultRecord), .retryExcessFault(retryExcessFault), .irq(irq));
	frs_fault_model model_u (.sys_clk(sys_clk), .inject(inject), .drop(drop),
		.faultClearPulse(faultClearPulse), .faultIn(faultIn));
	initial begin
		sys_clk = 1'b0;
		forever #10 sys_clk = ~sys_clk;
	end
	// Counted on the falling edge, clear of the edge that launches the pulse
	always @(negedge sys_clk) if (faultClearPulse === 1'b1) pulses++;
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checks++;
		if (got !== exp) begin
			errCount++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic final_report();
		$display("checks=%0d errCount=%0d", checks, errCount);
		if (errCount == 0 && checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask
	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge sys_clk);
		busReq <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge sys_clk);
		busReq.wr <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a, output logic [15:0] d);
		@(posedge sys_clk);
		busReq <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
		@(posedge sys_clk);
		busReq.rd <= 1'b0;
		#1 d = busRdata;
	endtask
	task automatic inj(input int i);
		@(posedge sys_clk);
		inject <= 15'h0001 << i;
		@(posedge sys_clk);
		inject <= 15'h0000;
	endtask
	task automatic release_trip();
		@(posedge sys_clk);
		drop <= 1'b1;
		externalReset <= 1'b1;
		tick(6);
		drop <= 1'b0;
		externalReset <= 1'b0;
		tick(6);
	endtask
	task automatic wait_pulse();
		for (int i = 0; i < 100 && faultClearPulse !== 1'b1; i++) tick(1);
	endtask
	task automatic t_defaults();
		logic [15:0] v;
		rd(4'h0, v); chk(v, 16'h0000);
		rd(4'h1, v); chk(v, 16'h0000);
		rd(4'h2, v); chk(v, 16'h000A);
		rd(4'h3, v); chk(v, 16'h0000);
		rd(4'h7, v); chk(v, 16'h0000);
		$display("test defaults done");
	endtask
	task automatic t_no_limit();
		p0 = pulses;
		inj(0);
		tick(60);
		chk(pulses - p0, 0);
		chk(driveTripped, 1);
		release_trip();
		chk(driveTripped, 0);
		$display("test no limit done");
	endtask
	task automatic t_retry();
		logic [15:0] v;
		wr(4'h2, 16'h0001);
		wr(4'h1, 16'h0001);
		wr(4'h6, 16'h000F);
		restartCoastTime <= 16'h0005;
		inj(0);
		tick(6);
		chk(driveTripped, 1);
		chk(faultOutput, 0);
		wait_pulse();
		chk(restartFromStart, 1);
		chk(keepThermalData, 1);
		chk(usePowerFailTiming, 1);
		chk(retryFaultRecord, 15'h0001);
		tick(2);
		chk(driveTripped, 0);
		tick(120);
		rd(4'h3, v); chk(v, 16'h0001);
		rd(4'h4, v); chk(v & 16'h00F0, 16'h0000);
		chk(irq, 1);
		wr(4'h5, 16'h000F);
		tick(1);
		chk(irq, 0);
		wr(4'h3, 16'h0000);
		rd(4'h3, v); chk(v, 16'h0000);
		$display("test retry done");
	endtask
	task automatic t_excess();
		restartCoastTime <= 16'h270F;
		wr(4'h1, 16'd101);
		inj(3);
		tick(6);
		chk(faultOutput, 1);
		wait_pulse();
		chk(usePowerFailTiming, 0);
		tick(5);
		p0 = pulses;
		inj(3);
		tick(60);
		chk(retryExcessFault, 1);
		chk(pulses - p0, 0);
		chk(driveTripped, 1);
		release_trip();
		chk(driveTripped, 0);
		$display("test excess done");
	endtask
	task automatic t_select();
		int bitOf[6] = '{6, 1, 4, 5, 7, 1};
		int yes[6] = '{1, 1, 1, 1, 0, 0};
		wr(4'h1, 16'd10);
		for (int s = 0; s < 6; s++) begin
			wr(4'h0, 16'(s));
			p0 = pulses;
			inj(bitOf[s]);
			tick(60);
			chk(16'(pulses - p0), 16'(yes[s]));
			release_trip();
		end
		wr(4'h0, 16'h0001);
		// Longer wait so the second fault lands well inside the wait
		wr(4'h2, 16'h0005);
		p0 = pulses;
		inj(0);
		tick(6);
		inj(3);
		tick(60);
		chk(pulses - p0, 0);
		chk(faultOutput, 1);
		release_trip();
		$display("test select done");
	endtask
	initial begin
		errCount = 0;
		checks = 0;
		pulses = 0;
		reset = 1'b1;
		busReq = '0;
		powerOnDone = 1'b0;
		externalReset = 1'b0;
		drop = 1'b0;
		inject = '0;
		restartCoastTime = 16'h270F;
		tick(2);
		reset <= 1'b0;
		powerOnDone <= 1'b1;
		t_defaults();
		t_no_limit();
		t_retry();
		t_excess();
		t_select();
		final_report();
	end
	// Whole run is near 900 cycles; give it ample margin
	initial begin
		#400000;
		errCount++;
		final_report();
	end
endmodule // fault_retry_sequencer_test

// ---- test/frs_fault_model.sv ----
// Purpose: detectors and power stage facing the retry sequencer
// Assumes: a fault level holds until the sequencer clears it or the bench drops it
// Notes:   inject is a one-cycle request from the bench
`timescale 1ns/1ns
module frs_fault_model (
	input  wire logic        sys_clk,
	input  wire logic [14:0] inject,
	input  wire logic        drop,
	input  wire logic        faultClearPulse,
	output logic      [14:0] faultIn
);
	initial faultIn = '0;
	// A cleared trip also clears the detectors, as a fresh start would
	always_ff @(posedge sys_clk) begin
		if (drop || faultClearPulse) begin
			faultIn <= '0;
		end else begin
			faultIn <= faultIn | inject;
		end
	end
endmodule // frs_fault_model
